// >>> core/lpmc_top.sv
// Low-power mode control: supply supervision, detector, regulator mode and sleep sequencing.
// Assumes an AXI4-Lite master on clk_sys and analog comparators and pins outside.
// Behaviour
// - Power-down reset supervision is always on and no register bit can disable it.
// - While supply is below the reset threshold the internal reset stays asserted.
// - The detector compares supply to a programmable threshold and flags fall, rise or both.
// - Regulator is main in run, main or low-power in stop, power-down with high-impedance in standby.
// - The regulator is enabled after every reset and switched off only in standby.
// - Light sleep halts only the core and any peripheral interrupt or event wakes it.
// - Stop gates all core-domain clocks and disables the PLL and fast oscillators.
// - During stop the regulator runs normal or low-power as chosen by software.
// - Stop is left on any event line: sixteen external lines, detector output or alarm.
// - Standby switches the regulator off and powers down the core domain and oscillators.
// - Standby loses core contents; only backup and standby circuitry keep values.
// - Standby is left on reset pin, watchdog reset, wake pin rising edge or alarm.
// - Calendar, watchdog and their clocks keep running in stop and standby.
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_defs.svh"
module lpmc_top #(
  parameter int NLINES = 16,
  parameter int RST_HOLD = `LPMC_RST_HOLD_CYC
) (
  input wire logic clk_sys, // System clock, 250 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write strobes.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  output logic [1:0] s_axi_bresp, // Write response.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  input wire logic supplyOkPin, // Supply above powerdown_reset threshold.
  input wire logic detAbovePin, // supply_level_detector comparator: above threshold.
  input wire logic wakePin, // wake_pin.
  input wire logic extResetPinN, // external_reset_pin, active low.
  input wire logic [NLINES-1:0] eventLines, // event_line_unit external lines.
  input wire logic periphIrq, // Any peripheral interrupt or event.
  input wire logic alarmEvent, // Calendar alarm, one cycle.
  input wire logic watchdogReset, // independent_watchdog reset, one cycle.
  input wire logic coreSuspend, // Core executes its suspend instruction, one cycle.
  output logic chipResetOut, // Internal chip reset.
  output logic coreHalt, // Core clock halted.
  output logic coreClockGate, // Core-domain clocks gated.
  output logic oscEnable, // PLL and fast oscillators enabled.
  output logic coreDomainPowered, // Core domain supply on.
  output logic [1:0] regulatorMode, // main_regulation, lowpower_regulation or power down.
  output logic regulatorEnable, // Regulator on; off means high-impedance output.
  output logic detectorIrq, // Detector crossing, level.
  output logic [2:0] detectorThreshold, // detector_threshold select.
  output logic alwaysOnRun // Calendar and watchdog clocks run.
);
  // The hold counter is 16 bits wide, so longer reset holds cannot be served.
  if (NLINES != 16 || RST_HOLD < 1 || RST_HOLD > 65535)
  begin : g_bad_params
    $error("lpmc_top: unsupported parameters");
  end
  lpmc_sync_if syncBus ();
  lpmc_sync #(.NLINES(NLINES)) uSync (
    .clk_sys(clk_sys),
    .rst(rst),
    .supplyOkAsync(supplyOkPin),
    .detAboveAsync(detAbovePin),
    .wakePinAsync(wakePin),
    .extResetNAsync(extResetPinN),
    .eventAsync(eventLines),
    .syncOut(syncBus)
  );
  // Register state.
  logic [31:0] ctrl_q, ctrl_d, det_q, det_d;
  logic [1:0] flag_q, flag_d;
  logic detPrev_q, detPrev_d, wakePrev_q, wakePrev_d;
  logic [NLINES-1:0] evPrev_q, evPrev_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d, bresp_q, bresp_d;
  lpmc_pkg::lpmc_state_t st_q, st_d;
  logic [15:0] hold_q, hold_d;
  logic [2:0] wakeSrc_q, wakeSrc_d;
  logic detEn, fallEn, riseEn, wrFire, rdFire, fallEv, riseEv, stopWake, stbyWake;
  logic evRise;
  assign detEn = det_q[`LPMC_DET_EN_BIT];
  assign fallEn = det_q[`LPMC_DET_FALL_BIT];
  assign riseEn = det_q[`LPMC_DET_RISE_BIT];
  assign fallEv = detEn && detPrev_q && !syncBus.detAbove;
  assign riseEv = detEn && !detPrev_q && syncBus.detAbove;
  assign evRise = |(syncBus.eventLine & ~evPrev_q);
  assign stopWake = evRise || fallEv || riseEv || alarmEvent;
  // Reset pin and watchdog are not here: they already reset the chip from any state.
  assign stbyWake = (syncBus.wakePin && !wakePrev_q) || alarmEvent;
  assign s_axi_awready = !bvalid_q && s_axi_awvalid && s_axi_wvalid;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = !rvalid_q;
  assign wrFire = s_axi_awready;
  assign rdFire = s_axi_arvalid && s_axi_arready;
  always_comb
  begin
    ctrl_d = ctrl_q;
    det_d = det_q;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    flag_d = flag_q;
    if (wrFire)
    begin
      bvalid_d = 1'b1;
      bresp_d = 2'b00;
      unique case (s_axi_awaddr)
        `LPMC_OFF_CTRL:
          for (int b = 0; b < 4; b++)
            if (s_axi_wstrb[b]) ctrl_d[8*b +: 8] = s_axi_wdata[8*b +: 8];
        `LPMC_OFF_DET:
          for (int b = 0; b < 4; b++)
            if (s_axi_wstrb[b]) det_d[8*b +: 8] = s_axi_wdata[8*b +: 8];
        `LPMC_OFF_STAT:
          if (s_axi_wstrb[0]) flag_d = flag_q & ~s_axi_wdata[1:0];
        `LPMC_OFF_WAKE: ;
        default: bresp_d = 2'b10;
      endcase
    end
    // Set wins over a clear in the same cycle.
    if (fallEv && fallEn) flag_d[0] = 1'b1;
    if (riseEv && riseEn) flag_d[1] = 1'b1;
    if (rdFire)
    begin
      rvalid_d = 1'b1;
      rresp_d = 2'b00;
      unique case (s_axi_araddr)
        `LPMC_OFF_CTRL: rdata_d = ctrl_q;
        `LPMC_OFF_DET: rdata_d = det_q;
        `LPMC_OFF_STAT: rdata_d = {24'h00_0000, 1'b0, st_q, syncBus.detAbove & detEn, 1'b0,
          flag_q};
        `LPMC_OFF_WAKE: rdata_d = {29'h0000_0000, wakeSrc_q};
        default:
        begin
          rdata_d = 32'h0000_0000;
          rresp_d = 2'b10;
        end
      endcase
    end
  end
  always_comb
  begin
    detPrev_d = syncBus.detAbove;
    wakePrev_d = syncBus.wakePin;
    evPrev_d = syncBus.eventLine;
  end
  // Sequencer.
  always_comb
  begin
    st_d = st_q;
    hold_d = hold_q;
    wakeSrc_d = wakeSrc_q;
    unique case (st_q)
      lpmc_pkg::LPMC_ST_RESET:
        if (hold_q == 16'h0000) st_d = lpmc_pkg::LPMC_ST_RUN;
        else hold_d = hold_q - 16'h0001;
      lpmc_pkg::LPMC_ST_RUN:
        if (coreSuspend)
        begin
          unique case (ctrl_q[`LPMC_CTRL_MODE_LSB +: 2])
            lpmc_pkg::LPMC_MODE_STOP: st_d = lpmc_pkg::LPMC_ST_STOP;
            lpmc_pkg::LPMC_MODE_STANDBY: st_d = lpmc_pkg::LPMC_ST_STANDBY;
            default: st_d = lpmc_pkg::LPMC_ST_SLEEP;
          endcase
        end
      lpmc_pkg::LPMC_ST_SLEEP:
        if (periphIrq || stopWake || flag_q != 2'b00)
        begin
          st_d = lpmc_pkg::LPMC_ST_RUN;
          wakeSrc_d = 3'h1;
        end
      lpmc_pkg::LPMC_ST_STOP:
        if (stopWake)
        begin
          st_d = lpmc_pkg::LPMC_ST_RUN;
          wakeSrc_d = 3'h2;
        end
      lpmc_pkg::LPMC_ST_STANDBY:
        if (stbyWake)
        begin
          st_d = lpmc_pkg::LPMC_ST_RESET;
          hold_d = 16'(RST_HOLD);
        end
      default: st_d = lpmc_pkg::LPMC_ST_RESET;
    endcase
    // Supply loss, reset pin and watchdog always force the reset sequence.
    if (!syncBus.supplyOk || !syncBus.extResetN || watchdogReset)
    begin
      st_d = lpmc_pkg::LPMC_ST_RESET;
      hold_d = 16'(RST_HOLD);
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_q <= lpmc_pkg::LPMC_ST_RESET;
      hold_q <= 16'(RST_HOLD);
      wakeSrc_q <= 3'h0;
    end
    else
    begin
      st_q <= st_d;
      hold_q <= hold_d;
      wakeSrc_q <= wakeSrc_d;
    end
  end
  // Core-domain registers are cleared by chipResetOut so standby state is not kept.
  always_ff @(posedge clk_sys)
  begin
    if (rst || st_q == lpmc_pkg::LPMC_ST_RESET)
    begin
      ctrl_q <= `LPMC_CTRL_RST;
      det_q <= `LPMC_DET_RST;
      flag_q <= 2'b00;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'b00;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      det_q <= det_d;
      flag_q <= flag_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      detPrev_q <= 1'b0;
      wakePrev_q <= 1'b0;
      evPrev_q <= '0;
    end
    else
    begin
      detPrev_q <= detPrev_d;
      wakePrev_q <= wakePrev_d;
      evPrev_q <= evPrev_d;
    end
  end
  // Outputs.
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign chipResetOut = (st_q == lpmc_pkg::LPMC_ST_RESET);
  assign coreHalt = (st_q != lpmc_pkg::LPMC_ST_RUN);
  assign coreClockGate = (st_q == lpmc_pkg::LPMC_ST_STOP) ||
    (st_q == lpmc_pkg::LPMC_ST_STANDBY);
  assign oscEnable = !coreClockGate;
  assign coreDomainPowered = (st_q != lpmc_pkg::LPMC_ST_STANDBY);
  assign regulatorEnable = (st_q != lpmc_pkg::LPMC_ST_STANDBY);
  always_comb
  begin
    unique case (st_q)
      lpmc_pkg::LPMC_ST_STOP:
        regulatorMode = ctrl_q[`LPMC_CTRL_REGLP_BIT] ? lpmc_pkg::LPMC_REG_LOWPOWER :
          lpmc_pkg::LPMC_REG_MAIN;
      lpmc_pkg::LPMC_ST_STANDBY: regulatorMode = lpmc_pkg::LPMC_REG_POWERDOWN;
      default: regulatorMode = lpmc_pkg::LPMC_REG_MAIN;
    endcase
  end
  assign detectorIrq = |flag_q;
  assign detectorThreshold = det_q[`LPMC_DET_THR_LSB +: `LPMC_DET_THR_W];
  assign alwaysOnRun = 1'b1;
  // Assertions.
  property p_supply_reset;
    @(posedge clk_sys) disable iff (rst) !syncBus.supplyOk |=> chipResetOut;
  endproperty
  a_supply_reset: assert property (p_supply_reset) else $error("low supply not in reset");
  property p_always_on;
    @(posedge clk_sys) disable iff (rst) alwaysOnRun;
  endproperty
  a_always_on: assert property (p_always_on) else $error("always-on clocks stopped");
  property p_stby_reg;
    @(posedge clk_sys) disable iff (rst) coreDomainPowered == regulatorEnable &&
      (!regulatorEnable == (regulatorMode == lpmc_pkg::LPMC_REG_POWERDOWN));
  endproperty
  a_stby_reg: assert property (p_stby_reg) else $error("regulator mismatch in standby");
  property p_reset_reg;
    @(posedge clk_sys) disable iff (rst) chipResetOut |-> regulatorEnable && !coreClockGate;
  endproperty
  a_reset_reg: assert property (p_reset_reg) else $error("regulator off in reset");
  property p_stop_wake;
    @(posedge clk_sys) disable iff (rst) st_q == lpmc_pkg::LPMC_ST_STOP && alarmEvent &&
      syncBus.supplyOk && syncBus.extResetN && !watchdogReset |=> !coreClockGate && !coreHalt;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("alarm did not end stop");
  property p_stby_exit;
    @(posedge clk_sys) disable iff (rst) st_q == lpmc_pkg::LPMC_ST_STANDBY && stbyWake |=>
      chipResetOut && regulatorEnable;
  endproperty
  a_stby_exit: assert property (p_stby_exit) else $error("standby exit skipped reset");
  property p_sleep_wake;
    @(posedge clk_sys) disable iff (rst) st_q == lpmc_pkg::LPMC_ST_SLEEP && periphIrq &&
      syncBus.supplyOk && syncBus.extResetN && !watchdogReset |=> !coreHalt;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep not woken");
  property p_stop_mode;
    @(posedge clk_sys) disable iff (rst) st_q == lpmc_pkg::LPMC_ST_STOP |->
      regulatorMode == (ctrl_q[`LPMC_CTRL_REGLP_BIT] ? 2'h1 : 2'h0) && !oscEnable;
  endproperty
  a_stop_mode: assert property (p_stop_mode) else $error("stop regulator or clock wrong");
  property p_fall_flag;
    @(posedge clk_sys) disable iff (rst) fallEv && fallEn && !chipResetOut |=> detectorIrq;
  endproperty
  a_fall_flag: assert property (p_fall_flag) else $error("fall not flagged");
  c_stop: cover property (@(posedge clk_sys) st_q == lpmc_pkg::LPMC_ST_STOP ##1 !coreClockGate);
  c_stby: cover property (@(posedge clk_sys) st_q == lpmc_pkg::LPMC_ST_STANDBY ##1 chipResetOut);
  c_irq: cover property (@(posedge clk_sys) $rose(detectorIrq));
endmodule : lpmc_top
`default_nettype wire

// >>> inc/lpmc_defs.svh
// Register offsets, field positions, reset values and timing counts of the low-power mode control.
// Assumes inclusion by bare name from design files only.
`ifndef LPMC_DEFS_SVH
`define LPMC_DEFS_SVH
`define LPMC_OFF_CTRL 8'h00
`define LPMC_OFF_DET 8'h04
`define LPMC_OFF_STAT 8'h08
`define LPMC_OFF_WAKE 8'h0C
`define LPMC_CTRL_MODE_LSB 0
`define LPMC_CTRL_REGLP_BIT 2
`define LPMC_DET_EN_BIT 0
`define LPMC_DET_FALL_BIT 1
`define LPMC_DET_RISE_BIT 2
`define LPMC_DET_THR_LSB 8
`define LPMC_DET_THR_W 3
`define LPMC_CTRL_RST 32'h0000_0000
`define LPMC_DET_RST 32'h0000_0000
`define LPMC_RST_HOLD_NS 1000
`define LPMC_CLK_NS 4
`define LPMC_RST_HOLD_CYC ((`LPMC_RST_HOLD_NS + `LPMC_CLK_NS - 1) / `LPMC_CLK_NS)
`endif

// >>> inc/lpmc_pkg.sv
// Types shared by the low-power mode control.
// Assumes no surroundings beyond the compiler.
package lpmc_pkg;
  typedef enum logic [1:0] {
    LPMC_MODE_SLEEP = 2'b00,
    LPMC_MODE_STOP = 2'b01,
    LPMC_MODE_STANDBY = 2'b10
  } lpmc_mode_t;
  typedef enum logic [2:0] {
    LPMC_ST_RESET = 3'b000,
    LPMC_ST_RUN = 3'b001,
    LPMC_ST_SLEEP = 3'b010,
    LPMC_ST_STOP = 3'b011,
    LPMC_ST_STANDBY = 3'b100
  } lpmc_state_t;
  typedef enum logic [1:0] {
    LPMC_REG_MAIN = 2'b00,
    LPMC_REG_LOWPOWER = 2'b01,
    LPMC_REG_POWERDOWN = 2'b10
  } lpmc_reg_t;
endpackage : lpmc_pkg

// >>> inc/lpmc_sync_if.sv
// Interface carrying synchronised supply and wake levels into the sequencer.
// Assumes one clock domain on both sides.
`timescale 1ns/1ps
`default_nettype none
interface lpmc_sync_if;
  logic supplyOk;
  logic detAbove;
  logic wakePin;
  logic extResetN;
  logic [15:0] eventLine;
  modport src (output supplyOk, output detAbove, output wakePin, output extResetN,
    output eventLine);
  modport dst (input supplyOk, input detAbove, input wakePin, input extResetN,
    input eventLine);
endinterface : lpmc_sync_if
`default_nettype wire

// >>> core/lpmc_sync.sv
// Two-flip-flop synchronisers for all asynchronous pins of the low-power mode control.
// Assumes pins are quasi-static or slower than two clock periods.
`timescale 1ns/1ps
`default_nettype none
module lpmc_sync #(
  parameter int NLINES = 16
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Synchronous reset.
  input wire logic supplyOkAsync, // Supply above reset threshold.
  input wire logic detAboveAsync, // Detector comparator output.
  input wire logic wakePinAsync, // Wake pin.
  input wire logic extResetNAsync, // External reset pin, active low.
  input wire logic [NLINES-1:0] eventAsync, // External event lines.
  lpmc_sync_if.src syncOut // Synchronised levels.
);
  localparam int W = NLINES + 4;
  logic [W-1:0] meta_q, meta_d, sync_q, sync_d;
  always_comb
  begin
    meta_d = {eventAsync, extResetNAsync, wakePinAsync, detAboveAsync, supplyOkAsync};
    sync_d = meta_q;
  end
  // Reset values are the safe side: supply low, reset pin asserted.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign syncOut.supplyOk = sync_q[0];
  assign syncOut.detAbove = sync_q[1];
  assign syncOut.wakePin = sync_q[2];
  assign syncOut.extResetN = sync_q[3];
  assign syncOut.eventLine = sync_q[W-1:4];
endmodule : lpmc_sync
`default_nettype wire

// >>> dv/lpmc_far_model.sv
// Far-side model: the core's suspend strobe and every wake, reset and supply source of the block.
// Assumes the bench calls its tasks from the clk_sys domain; pins change just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module lpmc_far_model (
  input wire logic clk_sys, // System clock.
  output var logic supplyOkPin, // Supply above reset threshold.
  output var logic detAbovePin, // Detector comparator level.
  output var logic wakePin, // Wake pin.
  output var logic extResetPinN, // Reset pin, active low.
  output var logic [15:0] eventLines, // External event lines.
  output var logic periphIrq, // Peripheral interrupt level.
  output var logic alarmEvent, // Calendar alarm pulse.
  output var logic watchdogReset, // Watchdog reset pulse.
  output var logic coreSuspend // Core suspend instruction.
);
  initial
  begin
    supplyOkPin = 1'b1;
    detAbovePin = 1'b1;
    wakePin = 1'b0;
    extResetPinN = 1'b1;
    eventLines = 16'h0000;
    periphIrq = 1'b0;
    alarmEvent = 1'b0;
    watchdogReset = 1'b0;
    coreSuspend = 1'b0;
  end
  // The bench sets mode and regulator choice over the bus before calling this.
  task automatic suspend();
    @(posedge clk_sys);
    coreSuspend <= 1'b1;
    @(posedge clk_sys);
    coreSuspend <= 1'b0;
  endtask : suspend
  // Sources 0 to 15 are event lines; 16 alarm, 17 detector fall, 18 wake pin, 19 watchdog,
  // 20 reset pin, 21 peripheral interrupt. Levels stand four cycles so the synchronisers see them.
  task automatic fire(input int src);
    @(posedge clk_sys);
    case (src)
      16: alarmEvent <= 1'b1;
      17: detAbovePin <= 1'b0;
      18: wakePin <= 1'b1;
      19: watchdogReset <= 1'b1;
      20: extResetPinN <= 1'b0;
      21: periphIrq <= 1'b1;
      default: eventLines[src] <= 1'b1;
    endcase
    @(posedge clk_sys);
    alarmEvent <= 1'b0;
    watchdogReset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    wakePin <= 1'b0;
    extResetPinN <= 1'b1;
    eventLines <= 16'h0000;
    periphIrq <= 1'b0;
    detAbovePin <= 1'b1;
  endtask : fire
  task automatic set_level(input logic supply, input logic above);
    @(posedge clk_sys);
    supplyOkPin <= supply;
    detAbovePin <= above;
  endtask : set_level
endmodule : lpmc_far_model
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench of the low-power mode control: bus, detector, sleep, stop, standby, supply.
// Assumes the far-side model drives all pins and the core strobe.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, regulatorMode;
  logic [31:0] s_axi_rdata;
  logic supplyOkPin, detAbovePin, wakePin, extResetPinN, periphIrq, alarmEvent;
  logic watchdogReset, coreSuspend, chipResetOut, coreHalt, coreClockGate, oscEnable;
  logic coreDomainPowered, regulatorEnable, detectorIrq, alwaysOnRun;
  logic [15:0] eventLines;
  logic [2:0] detectorThreshold;
  int numErrors = 0;
  int nChecks = 0;
  // A short reset hold keeps every standby exit to a few cycles.
  lpmc_top #(.NLINES(16), .RST_HOLD(4)) lpmc_top_inst (.clk_sys, .rst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .supplyOkPin, .detAbovePin,
    .wakePin, .extResetPinN, .eventLines, .periphIrq, .alarmEvent, .watchdogReset,
    .coreSuspend, .chipResetOut, .coreHalt, .coreClockGate, .oscEnable, .coreDomainPowered,
    .regulatorMode, .regulatorEnable, .detectorIrq, .detectorThreshold, .alwaysOnRun);
  lpmc_far_model lpmc_far_model_inst (.clk_sys, .supplyOkPin, .detAbovePin, .wakePin,
    .extResetPinN, .eventLines, .periphIrq, .alarmEvent, .watchdogReset, .coreSuspend);
  always #2 clk_sys = ~clk_sys;
  task automatic complete_run();
    $display("checks %0d errors %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    nChecks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: %s", $time, msg);
      numErrors++;
    end
  endtask : chk
  function automatic logic pick(input int sel);
    case (sel)
      0: return chipResetOut;
      1: return coreHalt;
      2: return coreClockGate;
      3: return detectorIrq;
      default: return regulatorEnable;
    endcase
  endfunction : pick
  // Outputs are judged at the falling edge, where the rising edge's updates have landed.
  task automatic wait_for(input int sel, input logic val);
    int n;
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (pick(sel) !== val && n < 60);
    chk({31'h0, pick(sel)}, {31'h0, val}, "output did not reach its level in time");
  endtask : wait_for
  // Ready and valid are stable between edges, so a falling-edge look predicts the rising edge.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(negedge clk_sys); while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
    @(posedge clk_sys);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(negedge clk_sys); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    @(posedge clk_sys);
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk_sys); while (s_axi_arready !== 1'b1);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk_sys); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge clk_sys);
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d & m, e, "register read");
  endtask : rd_chk
  task automatic t_reset();
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({chipResetOut, regulatorEnable, regulatorMode}, 32'h0000_000C, "reset outputs");
    @(posedge clk_sys);
    rst <= 1'b0;
    wait_for(0, 1'b0);
    chk({coreHalt, oscEnable, coreDomainPowered, alwaysOnRun}, 32'h0000_0007, "run");
  endtask : t_reset
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd_chk(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(8'h04, 32'h0000_0500);
    chk({29'h0, detectorThreshold}, 32'h0000_0005, "threshold out");
    axi_rd(8'h10, d, r);
    chk({r, d[29:0]}, 32'h8000_0000, "unmapped read");
    axi_wr(8'h14, 32'hFFFF_FFFF, r);
    chk({30'h0, r}, 32'h0000_0002, "unmapped write");
    wr(8'h04, 32'h0000_0000);
  endtask : t_regs
  task automatic t_detector();
    wr(8'h04, 32'h0000_0007);
    lpmc_far_model_inst.set_level(1'b1, 1'b0);
    wait_for(3, 1'b1);
    rd_chk(8'h08, 32'h0000_000B, 32'h0000_0001);
    lpmc_far_model_inst.set_level(1'b1, 1'b1);
    repeat (6) @(posedge clk_sys);
    rd_chk(8'h08, 32'h0000_000B, 32'h0000_000B);
    wr(8'h08, 32'h0000_0003);
    wait_for(3, 1'b0);
    wr(8'h04, 32'h0000_0000);
    lpmc_far_model_inst.set_level(1'b1, 1'b0);
    repeat (10) @(negedge clk_sys);
    chk({31'h0, detectorIrq}, 32'h0000_0000, "disabled detector flagged");
    lpmc_far_model_inst.set_level(1'b1, 1'b1);
  endtask : t_detector
  task automatic t_sleep(input logic [31:0] ctrl);
    wr(8'h00, ctrl);
    lpmc_far_model_inst.suspend();
    wait_for(1, 1'b1);
    chk({coreClockGate, oscEnable, regulatorMode}, 32'h0000_0004, "sleep outputs");
    lpmc_far_model_inst.fire(21);
    wait_for(1, 1'b0);
    rd_chk(8'h0C, 32'h0000_0007, 32'h0000_0001);
  endtask : t_sleep
  task automatic t_stop(input logic [31:0] ctrl, input int src);
    wr(8'h00, ctrl);
    lpmc_far_model_inst.suspend();
    wait_for(2, 1'b1);
    chk({oscEnable, regulatorEnable, coreDomainPowered, alwaysOnRun}, 32'h7, "stop");
    chk({30'h0, regulatorMode}, {31'h0, ctrl[2]}, "stop regulator");
    lpmc_far_model_inst.fire(src);
    wait_for(1, 1'b0);
    chk({coreClockGate, oscEnable}, 32'h0000_0001, "stop exit clocks");
    rd_chk(8'h0C, 32'h0000_0007, 32'h0000_0002);
  endtask : t_stop
  task automatic t_standby(input int src);
    wr(8'h04, 32'h0000_0500);
    wr(8'h00, 32'h0000_0002);
    lpmc_far_model_inst.suspend();
    wait_for(4, 1'b0);
    chk({regulatorMode, coreDomainPowered, oscEnable, alwaysOnRun}, 32'h11, "standby");
    lpmc_far_model_inst.fire(src);
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    rd_chk(8'h04, 32'hFFFF_FFFF, 32'h0000_0000);
  endtask : t_standby
  task automatic t_supply();
    int bad;
    bad = 0;
    wr(8'h00, 32'h0000_0007);
    lpmc_far_model_inst.set_level(1'b0, 1'b1);
    wait_for(0, 1'b1);
    repeat (20)
    begin
      @(negedge clk_sys);
      bad += (chipResetOut !== 1'b1);
    end
    chk(bad, 32'h0000_0000, "reset released on low supply");
    lpmc_far_model_inst.set_level(1'b1, 1'b1);
    wait_for(0, 1'b0);
  endtask : t_supply
  initial
  begin
    t_reset();
    t_regs();
    t_detector();
    t_sleep(32'h0000_0000);
    t_sleep(32'h0000_0003);
    for (int j = 0; j < 17; j++) t_stop({29'h0, j[0], 2'b01}, j);
    wr(8'h04, 32'h0000_0003);
    t_stop(32'h0000_0005, 17);
    wr(8'h08, 32'h0000_0003);
    // A detector crossing is no standby wake source, so source 17 is left out here.
    for (int s = 16; s < 21; s++) if (s != 17) t_standby(s);
    t_supply();
    complete_run();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    numErrors++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
